/* pkg/cpr_pkg.sv */
// Constants and types for the charger protection control register slice
package cpr_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PROT_DISABLE = 8'h12;
  localparam logic [7:0] ADDR_DISCHARGE = 8'h13;

  // Field positions in the protection disable register
  localparam int BIT_OUT_OV_OFF = 7;
  localparam int BIT_IN_OV_OFF = 6;
  localparam int BIT_DIE_OT_OFF = 5;
  localparam int BIT_IN_OC_OFF = 4;
  localparam int BIT_WRX_RC_OFF = 3;
  localparam int BIT_REG_RESET = 2;
  localparam int GUARD_LSB = 3;
  localparam int GUARD_W = 5;

  // Field position in the discharge register
  localparam int BIT_DISCHARGE_EN = 1;

  // Reset values
  localparam logic [GUARD_W-1:0] GUARD_OFF_RST = 5'h00;
  localparam logic REG_RESET_RST = 1'b0;
  localparam logic DISCHARGE_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Timing, figures in their own units and derived cycle counts
  localparam int CLK_PERIOD_NS = 40;
  localparam int INT_PULSE_US = 256;
  localparam int WDT_WAIT_MS = 32;
  localparam int INT_PULSE_CYC = (INT_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int WDT_WAIT_CYC = (WDT_WAIT_MS * 1000 * 1000) / CLK_PERIOD_NS;
  localparam int WDT_CNT_W = 24;

  // Switch sequencer: 500 kHz default period, 40 ns dead time between states
  localparam int SW_PERIOD_NS = 2000;
  localparam int SW_DEAD_NS = 40;
  localparam int SW_HALF_CYC = SW_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int SW_DEAD_CYC = (SW_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_CNT_W = 8;
  localparam int NUM_PHASES = 2;

  // Switch pattern, bit 0 is switch one
  localparam logic [3:0] SW_ALL_OFF = 4'h0;
  localparam logic [3:0] SW_ONE_THREE = 4'h5;
  localparam logic [3:0] SW_TWO_FOUR = 4'ha;

  typedef enum logic [1:0] {
    CPR_WDT_IDLE = 2'b00,
    CPR_WDT_PULSE = 2'b01,
    CPR_WDT_WAIT = 2'b10
  } cpr_wdt_state_t;

  typedef enum logic [2:0] {
    CPR_SW_OFF = 3'b000,
    CPR_SW_FIRST = 3'b001,
    CPR_SW_DEAD_A = 3'b010,
    CPR_SW_SECOND = 3'b011,
    CPR_SW_DEAD_B = 3'b100
  } cpr_sw_state_t;

endpackage : cpr_pkg

/* hw/cpr_switch_seq.sv */
// One phase of the divide-by-two switch sequencer
module cpr_switch_seq #(
  parameter logic START_SECOND = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  output logic [3:0] switch_o
);

  typedef struct packed {
    cpr_pkg::cpr_sw_state_t st;
    logic [cpr_pkg::SW_CNT_W-1:0] cnt;
    logic [3:0] sw;
  } cpr_seq_state_t;

  cpr_seq_state_t cur_ff;
  cpr_seq_state_t nxt_ff;

  localparam logic [cpr_pkg::SW_CNT_W-1:0] HOLD_LAST =
    cpr_pkg::SW_CNT_W'(cpr_pkg::SW_HALF_CYC - cpr_pkg::SW_DEAD_CYC - 1);
  localparam logic [cpr_pkg::SW_CNT_W-1:0] DEAD_LAST =
    cpr_pkg::SW_CNT_W'(cpr_pkg::SW_DEAD_CYC - 1);

  // Each half period is a conduction state plus a dead gap, so the two pairs never overlap
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.cnt = cur_ff.cnt + 1'b1;
    unique case (cur_ff.st)
      cpr_pkg::CPR_SW_OFF: begin
        nxt_ff.cnt = '0;
        if (run_i) begin
          nxt_ff.st = START_SECOND ? cpr_pkg::CPR_SW_SECOND : cpr_pkg::CPR_SW_FIRST;
        end
      end
      cpr_pkg::CPR_SW_FIRST: begin
        if (cur_ff.cnt == HOLD_LAST) begin
          nxt_ff.st = cpr_pkg::CPR_SW_DEAD_A;
          nxt_ff.cnt = '0;
        end
      end
      cpr_pkg::CPR_SW_DEAD_A: begin
        if (cur_ff.cnt == DEAD_LAST) begin
          nxt_ff.st = cpr_pkg::CPR_SW_SECOND;
          nxt_ff.cnt = '0;
        end
      end
      cpr_pkg::CPR_SW_SECOND: begin
        if (cur_ff.cnt == HOLD_LAST) begin
          nxt_ff.st = cpr_pkg::CPR_SW_DEAD_B;
          nxt_ff.cnt = '0;
        end
      end
      cpr_pkg::CPR_SW_DEAD_B: begin
        if (cur_ff.cnt == DEAD_LAST) begin
          nxt_ff.st = cpr_pkg::CPR_SW_FIRST;
          nxt_ff.cnt = '0;
        end
      end
      default: begin
        nxt_ff.st = cpr_pkg::CPR_SW_OFF;
        nxt_ff.cnt = '0;
      end
    endcase
    // Stopping drops every switch at once rather than finishing the period
    if (!run_i) begin
      nxt_ff.st = cpr_pkg::CPR_SW_OFF;
      nxt_ff.cnt = '0;
    end
    unique case (nxt_ff.st)
      cpr_pkg::CPR_SW_FIRST: nxt_ff.sw = cpr_pkg::SW_ONE_THREE;
      cpr_pkg::CPR_SW_SECOND: nxt_ff.sw = cpr_pkg::SW_TWO_FOUR;
      default: nxt_ff.sw = cpr_pkg::SW_ALL_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '{st: cpr_pkg::CPR_SW_OFF, cnt: '0, sw: cpr_pkg::SW_ALL_OFF};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign switch_o = cur_ff.sw;

endmodule : cpr_switch_seq

/* hw/cpr_regs.sv */
// Protection disable and discharge control registers with watchdog and switch sequencing
module cpr_regs #(
  parameter int INT_PULSE_CYCLES = cpr_pkg::INT_PULSE_CYC,
  parameter int WDT_WAIT_CYCLES = cpr_pkg::WDT_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // Byte register port from the serial slave engine
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Watchdog expiry event from the watchdog timer
  input wire logic watchdog_expire_i,
  output logic watchdog_kick_o,
  output logic int_n_o,
  output logic watchdog_reload_o,
  output logic register_reset_o,
  // Protection guard disables toward the analog comparators, then the output discharge enable
  output logic output_overvoltage_guard_off_o,
  output logic input_overvoltage_guard_off_o,
  output logic die_overtemp_guard_off_o,
  output logic input_overcurrent_guard_off_o,
  output logic wireless_reverse_current_guard_off_o,
  output logic output_discharge_enable_o,
  // Converter operation
  input wire logic divide_by_two_operation_i,
  input wire logic dual_phase_i,
  output logic [3:0] phase_a_switch_o,
  output logic [3:0] phase_b_switch_o
);

  localparam logic [cpr_pkg::WDT_CNT_W-1:0] PULSE_LAST =
    cpr_pkg::WDT_CNT_W'(INT_PULSE_CYCLES - 1);
  localparam logic [cpr_pkg::WDT_CNT_W-1:0] WAIT_LAST =
    cpr_pkg::WDT_CNT_W'(WDT_WAIT_CYCLES - 1);

  typedef struct packed {
    logic [cpr_pkg::GUARD_W-1:0] guard_off;
    logic reg_reset;
    logic discharge;
    logic [7:0] rdata;
    cpr_pkg::cpr_wdt_state_t wst;
    logic [cpr_pkg::WDT_CNT_W-1:0] wcnt;
    logic int_n;
    logic kick;
    logic reload;
    logic run_a;
    logic run_b;
  } cpr_regs_state_t;

  cpr_regs_state_t cur_ff;
  cpr_regs_state_t nxt_ff;

  logic wr_prot;
  logic wr_dis;
  logic [7:0] prot_view;
  logic [7:0] dis_view;

  // Address decode
  assign wr_prot = reg_wr_i && (reg_addr_i == cpr_pkg::ADDR_PROT_DISABLE);
  assign wr_dis = reg_wr_i && (reg_addr_i == cpr_pkg::ADDR_DISCHARGE);

  // Read views; reserved positions stay zero
  always_comb begin
    prot_view = 8'h00;
    prot_view[cpr_pkg::GUARD_LSB +: cpr_pkg::GUARD_W] = cur_ff.guard_off;
    prot_view[cpr_pkg::BIT_REG_RESET] = cur_ff.reg_reset;
    dis_view = 8'h00;
    dis_view[cpr_pkg::BIT_DISCHARGE_EN] = cur_ff.discharge;
  end

  // Next state of the whole block
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.kick = reg_wr_i || reg_rd_i;
    nxt_ff.reload = 1'b0;

    // Read data is captured one cycle after the strobe; unknown addresses read zero
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        cpr_pkg::ADDR_PROT_DISABLE: nxt_ff.rdata = prot_view;
        cpr_pkg::ADDR_DISCHARGE: nxt_ff.rdata = dis_view;
        default: nxt_ff.rdata = 8'h00;
      endcase
    end

    // Watchdog expiry: interrupt pulse, then a wait, then reload
    unique case (cur_ff.wst)
      cpr_pkg::CPR_WDT_IDLE: begin
        if (watchdog_expire_i) begin
          nxt_ff.wst = cpr_pkg::CPR_WDT_PULSE;
          nxt_ff.wcnt = '0;
          nxt_ff.int_n = 1'b0;
        end
      end
      cpr_pkg::CPR_WDT_PULSE: begin
        nxt_ff.wcnt = cur_ff.wcnt + 1'b1;
        if (cur_ff.wcnt == PULSE_LAST) begin
          nxt_ff.wst = cpr_pkg::CPR_WDT_WAIT;
          nxt_ff.wcnt = '0;
          nxt_ff.int_n = 1'b1;
        end
      end
      cpr_pkg::CPR_WDT_WAIT: begin
        nxt_ff.wcnt = cur_ff.wcnt + 1'b1;
        if (cur_ff.wcnt == WAIT_LAST) begin
          nxt_ff.wst = cpr_pkg::CPR_WDT_IDLE;
          nxt_ff.wcnt = '0;
          nxt_ff.reload = 1'b1;
        end
      end
      default: begin
        nxt_ff.wst = cpr_pkg::CPR_WDT_IDLE;
        nxt_ff.wcnt = '0;
        nxt_ff.int_n = 1'b1;
      end
    endcase

    // Host writes; reserved bits are simply not stored
    if (wr_prot) begin
      nxt_ff.guard_off =
        reg_wdata_i[cpr_pkg::GUARD_LSB +: cpr_pkg::GUARD_W];
      nxt_ff.reg_reset = reg_wdata_i[cpr_pkg::BIT_REG_RESET];
    end
    if (wr_dis) begin
      nxt_ff.discharge = reg_wdata_i[cpr_pkg::BIT_DISCHARGE_EN];
    end

    // Watchdog reload returns only the guard disables; reset command and discharge survive
    if (nxt_ff.reload) begin
      nxt_ff.guard_off = cpr_pkg::GUARD_OFF_RST;
    end

    // Register reset acts the cycle after the command bit is stored, then the bit clears
    if (cur_ff.reg_reset) begin
      nxt_ff.guard_off = cpr_pkg::GUARD_OFF_RST;
      nxt_ff.discharge = cpr_pkg::DISCHARGE_RST;
      // A fresh command in the clearing cycle wins, so the reset simply runs once more
      if (!(wr_prot && reg_wdata_i[cpr_pkg::BIT_REG_RESET])) begin
        nxt_ff.reg_reset = cpr_pkg::REG_RESET_RST;
      end
    end

    // Switching only in divide-by-two; phase B only when dual phase is chosen
    nxt_ff.run_a = divide_by_two_operation_i;
    nxt_ff.run_b = divide_by_two_operation_i && dual_phase_i;
  end

  // Whole state in one register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '{
        guard_off: cpr_pkg::GUARD_OFF_RST,
        reg_reset: cpr_pkg::REG_RESET_RST,
        discharge: cpr_pkg::DISCHARGE_RST,
        rdata: cpr_pkg::RDATA_RST,
        wst: cpr_pkg::CPR_WDT_IDLE,
        wcnt: '0,
        int_n: 1'b1,
        kick: 1'b0,
        reload: 1'b0,
        run_a: 1'b0,
        run_b: 1'b0
      };
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o = cur_ff.rdata;
  assign watchdog_kick_o = cur_ff.kick;
  assign int_n_o = cur_ff.int_n;
  assign watchdog_reload_o = cur_ff.reload;
  assign register_reset_o = cur_ff.reg_reset;
  assign output_overvoltage_guard_off_o =
    cur_ff.guard_off[cpr_pkg::BIT_OUT_OV_OFF - cpr_pkg::GUARD_LSB];
  assign input_overvoltage_guard_off_o =
    cur_ff.guard_off[cpr_pkg::BIT_IN_OV_OFF - cpr_pkg::GUARD_LSB];
  assign die_overtemp_guard_off_o =
    cur_ff.guard_off[cpr_pkg::BIT_DIE_OT_OFF - cpr_pkg::GUARD_LSB];
  assign input_overcurrent_guard_off_o =
    cur_ff.guard_off[cpr_pkg::BIT_IN_OC_OFF - cpr_pkg::GUARD_LSB];
  assign wireless_reverse_current_guard_off_o =
    cur_ff.guard_off[cpr_pkg::BIT_WRX_RC_OFF - cpr_pkg::GUARD_LSB];
  assign output_discharge_enable_o = cur_ff.discharge;

  // With dual phase chosen before divide-by-two starts, both phase sequencers start on the same edge, so starting B in the second state
  // gives exactly half a period of offset without a second timebase
  logic [cpr_pkg::NUM_PHASES-1:0] phase_run;
  logic [3:0] phase_sw [cpr_pkg::NUM_PHASES];

  assign phase_run = {cur_ff.run_b, cur_ff.run_a};

  for (genvar p = 0; p < cpr_pkg::NUM_PHASES; p++) begin : g_phase
    cpr_switch_seq #(
      .START_SECOND(1'(p))
    ) u_seq (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .run_i(phase_run[p]),
      .switch_o(phase_sw[p])
    );
  end

  assign phase_a_switch_o = phase_sw[0];
  assign phase_b_switch_o = phase_sw[1];

endmodule : cpr_regs

/* tb/cpr_regs_properties.sv */
// Concurrent checks on the ports of the charger protection register slice
module cpr_regs_properties #(
  parameter int INT_PULSE_CYCLES = 4,
  parameter int WDT_WAIT_CYCLES = 6
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic watchdog_expire_i,
  input wire logic int_n_o,
  input wire logic watchdog_reload_o,
  input wire logic register_reset_o,
  input wire logic output_overvoltage_guard_off_o,
  input wire logic input_overvoltage_guard_off_o,
  input wire logic die_overtemp_guard_off_o,
  input wire logic input_overcurrent_guard_off_o,
  input wire logic wireless_reverse_current_guard_off_o,
  input wire logic output_discharge_enable_o,
  input wire logic dual_phase_i,
  input wire logic [3:0] phase_a_switch_o,
  input wire logic [3:0] phase_b_switch_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PULSE_LAST = INT_PULSE_CYCLES - 1;
  // Guard disables in register order, bit 4 is the output overvoltage one
  wire logic [4:0] guards = {output_overvoltage_guard_off_o, input_overvoltage_guard_off_o,
    die_overtemp_guard_off_o, input_overcurrent_guard_off_o, wireless_reverse_current_guard_off_o};
  wire logic wr_prot = reg_wr_i && reg_addr_i == cpr_pkg::ADDR_PROT_DISABLE;
  wire logic reset_cmd = wr_prot && reg_wdata_i[2];
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // A pending register reset or reload outranks a guard write
  a_guard_write: assert property (wr_prot && !reg_wdata_i[2]
    && !register_reset_o |=> watchdog_reload_o || guards == $past(reg_wdata_i[7:3]))
    else $error("guards do not follow write");
  a_reg_reset: assert property (wr_prot && reg_wdata_i[2] |=> register_reset_o
    ##1 ((!register_reset_o || $past(reset_cmd)) && guards == 5'h00
    && !output_discharge_enable_o))
    else $error("register reset failed");
  a_discharge_write: assert property (reg_wr_i && !register_reset_o
    && reg_addr_i == cpr_pkg::ADDR_DISCHARGE
    |=> output_discharge_enable_o == $past(reg_wdata_i[1]))
    else $error("discharge does not follow write");
  // Conduction changes only through all-off, so the pairs never overlap
  a_dead_time: assert property ($changed(phase_a_switch_o) |->
    phase_a_switch_o == 4'h0 || $past(phase_a_switch_o) == 4'h0)
    else $error("no dead cycle");
  a_phase_offset: assert property (dual_phase_i && $past(dual_phase_i, 2)
    && phase_a_switch_o != 4'h0 |-> phase_b_switch_o == ~phase_a_switch_o)
    else $error("phase b not half a period away");
  a_int_pulse: assert property ($fell(int_n_o) |-> $past(watchdog_expire_i) ##0
    (!int_n_o throughout ##PULSE_LAST 1'b1) ##1 int_n_o)
    else $error("interrupt pulse wrong");
  a_reload_wait: assert property ($rose(int_n_o) |->
    ##WDT_WAIT_CYCLES (watchdog_reload_o && guards == 5'h00))
    else $error("reload late or incomplete");
  a_reserved_read: assert property (reg_rd_i |=> (reg_rdata_o & (
    $past(reg_addr_i) == cpr_pkg::ADDR_PROT_DISABLE ? 8'h03 :
    $past(reg_addr_i) == cpr_pkg::ADDR_DISCHARGE ? 8'hfd : 8'hff)) == 8'h00)
    else $error("reserved bits read nonzero");
  c_reg_reset: cover property (register_reset_o);
  c_reload: cover property (watchdog_reload_o);
  c_dual: cover property (phase_b_switch_o == 4'h5);
endmodule : cpr_regs_properties

/* tb/cpr_host.sv */
// Host processor model driving the byte register port
module cpr_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle port before the first access
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One strobe cycle per byte; address and data invert afterwards so stale use shows
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk_i);
    wr_o = wr;
    rd_o = !wr;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : access
endmodule : cpr_host

/* tb/tb_top.sv */
// Self-checking bench for the charger protection register slice
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, reset_i, reg_wr_i, reg_rd_i, watchdog_expire_i, int_n_o, watchdog_reload_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q, lo, at;
  logic register_reset_o, output_discharge_enable_o, divide_by_two_operation_i, dual_phase_i;
  logic output_overvoltage_guard_off_o, input_overvoltage_guard_off_o, die_overtemp_guard_off_o;
  logic input_overcurrent_guard_off_o, wireless_reverse_current_guard_off_o;
  logic [3:0] phase_a_switch_o, phase_b_switch_o;
  logic watchdog_kick_o;
  int n_tests = 0;
  int n_mismatch = 0;
  // Guards placed at their register bit positions
  wire logic [7:0] guards = {output_overvoltage_guard_off_o, input_overvoltage_guard_off_o,
    die_overtemp_guard_off_o, input_overcurrent_guard_off_o, wireless_reverse_current_guard_off_o,
    3'h0};
  cpr_regs #(.INT_PULSE_CYCLES(4), .WDT_WAIT_CYCLES(6)) cpr_regs_inst (.clk_i, .reset_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .watchdog_expire_i,
    .watchdog_kick_o, .int_n_o, .watchdog_reload_o, .register_reset_o,
    .output_overvoltage_guard_off_o, .input_overvoltage_guard_off_o, .die_overtemp_guard_off_o,
    .input_overcurrent_guard_off_o, .wireless_reverse_current_guard_off_o,
    .output_discharge_enable_o, .divide_by_two_operation_i, .dual_phase_i,
    .phase_a_switch_o, .phase_b_switch_o);
  cpr_host cpr_host_inst (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpr_host_inst.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cpr_host_inst.access(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic finish_test();
    $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Sequence needs about 130 cycles; the limit leaves a wide margin
  initial begin
    #40us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset_i = 1'b1;
    watchdog_expire_i = 1'b0;
    divide_by_two_operation_i = 1'b0;
    dual_phase_i = 1'b0;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    rd(8'h12);
    check(q, 8'h00);
    rd(8'h13);
    check(q, 8'h00);
    $display("Test defaults finished");
    for (int i = 3; i < 8; i++) begin
      wr(8'h12, 8'h01 << i);
      check(guards, 8'h01 << i);
      rd(8'h12);
      check(q, 8'h01 << i);
    end
    wr(8'h12, 8'hfb);
    rd(8'h12);
    check(q, 8'hf8);
    wr(8'h13, 8'hff);
    rd(8'h13);
    check(q, 8'h02);
    wr(8'h14, 8'hff);
    rd(8'h14);
    check(q, 8'h00);
    $display("Test fields finished");
    // Zero in the reset bit keeps the map; a one clears it even with guard bits set
    wr(8'h12, 8'h00);
    check({7'h00, output_discharge_enable_o}, 8'h01);
    wr(8'h12, 8'hfc);
    check({7'h00, register_reset_o}, 8'h01);
    rd(8'h12);
    check(q, 8'h00);
    rd(8'h13);
    check(q, 8'h00);
    $display("Test register reset finished");
    wr(8'h12, 8'hf8);
    wr(8'h13, 8'h02);
    check({7'h00, watchdog_kick_o}, 8'h01);
    @(negedge clk_i);
    check({7'h00, watchdog_kick_o}, 8'h00);
    watchdog_expire_i = 1'b1;
    @(negedge clk_i);
    watchdog_expire_i = 1'b0;
    lo = 8'h00;
    at = 8'h00;
    for (int k = 1; k < 30; k++) begin
      if (int_n_o === 1'b0) lo++;
      if (watchdog_reload_o === 1'b1) at = 8'(k);
      @(negedge clk_i);
    end
    check(lo, 8'h04);
    check(at, 8'h0b);
    check(guards, 8'h00);
    check({7'h00, output_discharge_enable_o}, 8'h01);
    rd(8'h12);
    check(q, 8'h00);
    $display("Test watchdog finished");
    // Protection setup is complete before the converter starts
    dual_phase_i = 1'b1;
    divide_by_two_operation_i = 1'b1;
    lo = 8'h00;
    for (int k = 0; k < 10 && phase_a_switch_o !== 4'h5; k++) @(negedge clk_i);
    check({4'h0, phase_b_switch_o}, 8'h0a);
    while (phase_a_switch_o === 4'h5 && lo < 8'h3c) begin
      lo++;
      @(negedge clk_i);
    end
    check(lo, 8'h18);
    check({phase_a_switch_o, phase_b_switch_o}, 8'h00);
    @(negedge clk_i);
    check({phase_a_switch_o, phase_b_switch_o}, 8'ha5);
    divide_by_two_operation_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check({phase_a_switch_o, phase_b_switch_o}, 8'h00);
    // Single phase: the second sequencer must stay off
    dual_phase_i = 1'b0;
    divide_by_two_operation_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check({phase_a_switch_o, phase_b_switch_o}, 8'h50);
    divide_by_two_operation_i = 1'b0;
    $display("Test switching finished");
    finish_test();
  end
endmodule : tb_top
bind cpr_regs cpr_regs_properties #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES),
  .WDT_WAIT_CYCLES(WDT_WAIT_CYCLES)) cpr_regs_properties_inst (.clk_i, .reset_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .watchdog_expire_i, .int_n_o,
  .watchdog_reload_o, .register_reset_o, .output_overvoltage_guard_off_o,
  .input_overvoltage_guard_off_o, .die_overtemp_guard_off_o, .input_overcurrent_guard_off_o,
  .wireless_reverse_current_guard_off_o, .output_discharge_enable_o, .dual_phase_i,
  .phase_a_switch_o, .phase_b_switch_o);
